// ### fdc_pos_pkg.sv
// Package with constants and types for the head positioning control block
package fdc_pos_pkg;
    // ****************************************************
    // Avalon register offsets (byte addresses)
    // ****************************************************
    localparam logic [5:0] CMD_OFS = 6'h00;
    localparam logic [5:0] ARG_OFS = 6'h04;
    localparam logic [5:0] STEP_OFS = 6'h08;
    localparam logic [5:0] CTRL_OFS = 6'h0C;
    localparam logic [5:0] STAT_OFS = 6'h10;
    localparam logic [5:0] RES_OFS = 6'h14;
    localparam logic [5:0] ID_OFS = 6'h18;
    localparam logic [5:0] FMT_OFS = 6'h1C;
    // ****************************************************
    // Command codes written to the command register
    // ****************************************************
    localparam logic [3:0] OP_READ_ID = 4'hA;
    localparam logic [3:0] OP_RECAL = 4'h7;
    localparam logic [3:0] OP_SEEK = 4'hF;
    localparam logic [3:0] OP_SENSE_INT = 4'h8;
    localparam logic [3:0] OP_SENSE_DRV = 4'h4;
    localparam logic [3:0] OP_LOW_POWER = 4'h1;
    localparam logic [3:0] OP_WAKE = 4'h2;
    // ****************************************************
    // Status field positions and codes
    // ****************************************************
    localparam int TC_LSB = 6;
    localparam int MOVE_BIT = 5;
    localparam int FAULT_BIT = 4;
    localparam int SIDE_BIT = 2;
    localparam logic [1:0] TC_NORMAL = 2'h0;
    localparam logic [1:0] TC_ABNORMAL = 2'h1;
    localparam logic [1:0] TC_POLLING = 2'h3;
    localparam logic [7:0] RECAL_MAX_STEPS = 8'h4F;
    localparam logic [1:0] INDEX_LIMIT = 2'h2;
    // ****************************************************
    // Single density format gap layout
    // ****************************************************
    localparam logic [7:0] SD_GAP_FILL = 8'hFF;
    localparam logic [7:0] SD_SYNC_FILL = 8'h00;
    localparam logic [7:0] SD_GAP4A_LEN = 8'h28;
    localparam logic [7:0] SD_GAP1_LEN = 8'h1A;
    localparam logic [7:0] SD_GAP2_LEN = 8'h0B;
    // ****************************************************
    // Step timing
    // ****************************************************
    localparam int CLOCK_HZ = 25000000;
    localparam int STEP_PULSE_NS = 4000;
    localparam int STEP_PULSE_CYC = (STEP_PULSE_NS * (CLOCK_HZ / 1000000) + 999) / 1000;
    localparam int STEP_UNIT_US = 500;
    localparam int STEP_UNIT_CYC = STEP_UNIT_US * (CLOCK_HZ / 1000000);
    localparam logic [3:0] STEP_RESET = 4'h8;
    localparam logic [7:0] CTRL_RESET = 8'h00;
    // Drive sequencer states
    typedef enum logic [1:0] {
        MV_IDLE = 2'b00,
        MV_PULSE = 2'b01,
        MV_WAIT = 2'b10,
        MV_DONE = 2'b11
    } move_state_t;
endpackage : fdc_pos_pkg

// ### fdd_model.sv
// Four drive mechanisms: head position, track zero sensor, index hole
`timescale 1ns/1ns
module fdd_model (
    input wire logic clock,
    input wire logic [3:0] stepPulse,
    input wire logic [3:0] stepHeading,
    output logic [3:0] trackZero,
    output logic indexPulse
);
    int pos [4] = '{5, 0, 0, 100};
    logic [3:0] prevReg = 4'h0;
    int cyc = 0;
    // Head moves one track per rising step; the end stop blocks outward travel
    always @(posedge clock) begin
        prevReg <= stepPulse;
        cyc <= cyc + 1;
        for (int d = 0; d < 4; d++) begin
            if (stepPulse[d] && !prevReg[d] && stepHeading[d]) pos[d] <= pos[d] + 1;
            else if (stepPulse[d] && !prevReg[d] && pos[d] > 0) pos[d] <= pos[d] - 1;
        end
    end
    // Sensor is high only with the head on track zero
    always_comb for (int d = 0; d < 4; d++) trackZero[d] = (pos[d] == 0);
    assign indexPulse = (cyc % 4000) < 20;
endmodule : fdd_model

// ### fhpc_properties.sv
// Checker on the bus, step and interrupt ports of the positioning block
`timescale 1ns/1ns
module fhpc_properties (
    input wire logic clock, rst, avs_read, avs_write, avs_waitrequest, controller_irq_out,
    input wire logic [5:0] avs_address,
    input wire logic [31:0] avs_writedata, avs_readdata,
    input wire logic [3:0] track_zero_input, step_pulse_out, step_heading_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    // Completed read and a sense drive command being taken
    wire logic rdDone = avs_read && !avs_waitrequest;
    wire logic sdCmd = avs_write && !avs_waitrequest && avs_address == fdc_pos_pkg::CMD_OFS
        && avs_writedata[3:0] == fdc_pos_pkg::OP_SENSE_DRV;
    bus_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest
        |-> ##[1:2] !avs_waitrequest) else $error("bus request unanswered");
    ack_single_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low over one cycle");
    gap_layout_a: assert property (
        rdDone && avs_address == fdc_pos_pkg::FMT_OFS |-> avs_readdata == 32'hFF281A0B)
        else $error("single density layout word wrong");
    unmapped_zero_a: assert property (rdDone && avs_address == 6'h3C |-> avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    sense_quiet_a: assert property (sdCmd && !controller_irq_out |=> !controller_irq_out [*4])
        else $error("sense drive raised interrupt");
    // Interrupt may only fall in the wake of a host command write
    irq_kept_a: assert property (controller_irq_out && !avs_write && !$past(avs_write)
        |=> controller_irq_out) else $error("interrupt dropped without command");
    step_width_a: assert property ($rose(step_pulse_out[0]) |=> step_pulse_out[0] [*8])
        else $error("step pulse too short");
    heading_held_a: assert property (step_pulse_out[0] && $past(step_pulse_out[0])
        |-> $stable(step_heading_out[0])) else $error("direction moved during step");
    zero_inward_a: assert property ($rose(step_pulse_out[0]) && track_zero_input[0]
        |-> step_heading_out[0]) else $error("outward step at track zero");
    cover property ($rose(step_pulse_out[0]) && step_heading_out[0]);
    cover property ($rose(step_pulse_out[0]) && !step_heading_out[0]);
    cover property ($rose(controller_irq_out));
endmodule : fhpc_properties

// ### floppy_head_positioning_control.sv
// Top block: command interpreter for positioning, read ID and sense commands
`timescale 1ns/1ns
// Function
// - Single density format uses FF gaps, 00 sync, gaps of 40, 26, 11 bytes.
// - Only read ID, recalibrate and seek raise an interrupt among control commands.
// - Read ID captures cylinder, head, sector, size of first good ID field.
// - No ID mark by second index pulse: abnormal code and absent ID flag.
// - Recalibrate clears track count, direction out, steps while track zero low.
// - Track zero high during recalibrate sets move complete and ends it.
// - After 79 steps without track zero: move complete plus fault, end.
// - Busy is set for one cycle by other commands, never by seek or recalibrate; moving bits cover up to four drives.
// - Seek direction inward when present track below target, outward when above.
// - Seek steps at programmed interval, recompares, ends with move complete.
// - No result phase for seeks; reported side bit always zero.
// - Leaving low power clears track counts and pending status.
// - Interrupt on result phase, end of moves, and non-DMA transfer request.
// - Sense interrupt clears the interrupt and returns primary status.
// - Causes: polling 0/11, normal end 1/00, abnormal end 1/01.
// - Without sense interrupt or wake, the drive's pending bit stays set, but its moving bit clears.
// - Sense drive status goes straight to result with status register 3.
// - Polling enabled by default raises one interrupt after reset.
// - Non-DMA mode signals each byte by transfer request and interrupt.
// - Step interval comes from the setting; first interval may be shorter.
module floppy_head_positioning_control #(
    parameter int DRIVES = 4,
    parameter int STEP_UNIT = fdc_pos_pkg::STEP_UNIT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic [3:0] track_zero_input,
    input wire logic index_pulse_input,
    input wire logic id_field_valid,
    input wire logic [31:0] id_field_data,
    input wire logic byte_request,
    input wire logic result_phase_event,
    input wire logic head_settled,
    output logic [3:0] step_pulse_out,
    output logic [3:0] step_heading_out,
    output logic controller_irq_out,
    output logic transfer_request_flag
);
    // ****************************************************
    // Register bus
    // ****************************************************
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic [7:0] target_reg;
    logic [1:0] drive_reg;
    logic [3:0] step_interval_setting_reg;
    logic [7:0] ctrl_reg; // [0]=pio_transfer_select [1]=polling disable
    logic [7:0] result_reg;
    logic [31:0] id_reg;
    logic busy_reg;
    logic lowpower_reg;
    logic readid_reg;
    logic [1:0] index_reg;
    logic index_prev_reg;
    logic pollPend_reg;
    logic irq_reg;
    logic xfer_reg;
    logic [3:0] stepOut_reg;
    logic [3:0] headOut_reg;
    logic [3:0] pend_reg;
    logic [3:0] pendFault_reg;
    logic [3:0] stepPulse;
    logic [3:0] stepHead;
    logic [3:0] moveDone;
    logic [3:0] moveFault;
    logic [3:0] moving;
    logic [7:0] track [4];

    wire logic access = (avs_read || avs_write) && !ack_reg;
    wire logic wrStrobe = avs_write && ack_reg;
    wire logic cmdWrite = wrStrobe && (avs_address == fdc_pos_pkg::CMD_OFS);
    wire logic [3:0] opcode = avs_writedata[3:0];
    wire logic [1:0] cmdDrive = avs_writedata[5:4];
    wire logic opRecal = cmdWrite && (opcode == fdc_pos_pkg::OP_RECAL);
    wire logic opSeek = cmdWrite && (opcode == fdc_pos_pkg::OP_SEEK);
    wire logic opSense = cmdWrite && (opcode == fdc_pos_pkg::OP_SENSE_INT);
    wire logic opDrive = cmdWrite && (opcode == fdc_pos_pkg::OP_SENSE_DRV);
    wire logic opReadId = cmdWrite && (opcode == fdc_pos_pkg::OP_READ_ID);
    wire logic opSleep = cmdWrite && (opcode == fdc_pos_pkg::OP_LOW_POWER);
    wire logic opWake = cmdWrite && (opcode == fdc_pos_pkg::OP_WAKE) && lowpower_reg;
    wire logic pioMode = ctrl_reg[0];
    wire logic pollOn = !ctrl_reg[1];
    wire logic indexRise = index_pulse_input && !index_prev_reg;
    // Lowest drive with pending completion answers the sense command first
    wire logic [1:0] pendIdx = pend_reg[0] ? 2'd0 : pend_reg[1] ? 2'd1 :
                               pend_reg[2] ? 2'd2 : 2'd3;
    wire logic anyPend = |pend_reg;
    wire logic [1:0] senseCode = pendFault_reg[pendIdx] ? fdc_pos_pkg::TC_ABNORMAL
                                                         : fdc_pos_pkg::TC_NORMAL;
    // Side bit left zero in every primary status image
    wire logic [7:0] senseStatus = anyPend ?
        {senseCode, 1'b1, pendFault_reg[pendIdx], 1'b0, 1'b0, pendIdx} :
        pollPend_reg ? {fdc_pos_pkg::TC_POLLING, 6'h00} :
        {fdc_pos_pkg::TC_ABNORMAL + 2'h1, 6'h00};
    // Drive status image: bit 5 set, track zero, head bit zero, drive number
    wire logic [7:0] driveStatus = {3'b001, track_zero_input[cmdDrive], 1'b0, 1'b0, cmdDrive};
    wire logic [31:0] statusWord = {19'h00000, lowpower_reg, readid_reg, busy_reg,
                                    moving, pend_reg, transfer_request_flag, irq_reg};
    wire logic [31:0] readMux =
        (avs_address == fdc_pos_pkg::ARG_OFS) ? {22'h000000, drive_reg, target_reg} :
        (avs_address == fdc_pos_pkg::STEP_OFS) ? {28'h0000000, step_interval_setting_reg} :
        (avs_address == fdc_pos_pkg::CTRL_OFS) ? {24'h000000, ctrl_reg} :
        (avs_address == fdc_pos_pkg::STAT_OFS) ? statusWord :
        (avs_address == fdc_pos_pkg::RES_OFS) ? {24'h000000, result_reg} :
        (avs_address == fdc_pos_pkg::ID_OFS) ? id_reg :
        (avs_address == fdc_pos_pkg::FMT_OFS) ? {fdc_pos_pkg::SD_GAP_FILL,
            fdc_pos_pkg::SD_GAP4A_LEN, fdc_pos_pkg::SD_GAP1_LEN, fdc_pos_pkg::SD_GAP2_LEN} :
        32'h00000000; // unmapped and command register read as zero

    // ****************************************************
    // Per-drive step sequencers
    // ****************************************************
    genvar d;
    generate
        for (d = 0; d < DRIVES; d++) begin : g_drive
            step_if sif ();
            assign sif.startRecal = opRecal && (cmdDrive == 2'(d)) && !moving[d];
            assign sif.startSeek = opSeek && (cmdDrive == 2'(d)) && !moving[d];
            assign sif.targetTrack = (cmdDrive == 2'(d) && opSeek) ? avs_writedata[15:8]
                                                                    : target_reg;
            assign sif.stepIntervalSetting = step_interval_setting_reg;
            assign sif.clearTrack = opWake;
            assign sif.trackZeroInput = track_zero_input[d];
            assign stepPulse[d] = sif.stepPulse;
            assign stepHead[d] = sif.stepHeading;
            assign moveDone[d] = sif.moveDone;
            assign moveFault[d] = sif.moveFault;
            assign moving[d] = sif.moving;
            assign track[d] = sif.presentTrackCount;
            step_sequencer #(.STEP_UNIT(STEP_UNIT)) u_seq (
                .clock(clock),
                .rst(rst),
                .sif(sif)
            );
        end
    endgenerate

    // Bus handshake: one wait cycle, then answer
    always_ff @(posedge clock) begin
        if (rst) begin
            ack_reg <= 1'b0;
            rdata_reg <= 32'h00000000;
        end else begin
            ack_reg <= access;
            rdata_reg <= readMux;
        end
    end
    assign avs_waitrequest = !ack_reg;
    assign avs_readdata = rdata_reg;

    // Setting registers written by software
    always_ff @(posedge clock) begin
        if (rst) begin
            target_reg <= 8'h00;
            drive_reg <= 2'h0;
            step_interval_setting_reg <= fdc_pos_pkg::STEP_RESET;
            ctrl_reg <= fdc_pos_pkg::CTRL_RESET;
        end else if (wrStrobe) begin
            if (avs_address == fdc_pos_pkg::ARG_OFS) {drive_reg, target_reg} <= avs_writedata[9:0];
            if (avs_address == fdc_pos_pkg::STEP_OFS) step_interval_setting_reg <= avs_writedata[3:0];
            if (avs_address == fdc_pos_pkg::CTRL_OFS) ctrl_reg <= avs_writedata[7:0];
        end
    end

    // Pending completions per drive; a completion beats a same-cycle clear
    always_ff @(posedge clock) begin
        if (rst) begin
            pend_reg <= 4'h0;
            pendFault_reg <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (moveDone[i]) begin
                    pend_reg[i] <= 1'b1;
                    pendFault_reg[i] <= moveFault[i];
                end else if ((opSense && anyPend && pendIdx == 2'(i)) || opWake) begin
                    pend_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Command phase, read ID search and result image
    always_ff @(posedge clock) begin
        if (rst) begin
            busy_reg <= 1'b0;
            lowpower_reg <= 1'b0;
            readid_reg <= 1'b0;
            index_reg <= 2'h0;
            index_prev_reg <= 1'b0;
            result_reg <= 8'h00;
            id_reg <= 32'h00000000;
        end else begin
            index_prev_reg <= index_pulse_input;
            busy_reg <= cmdWrite && !opRecal && !opSeek;
            if (opSleep) lowpower_reg <= 1'b1;
            if (opWake) lowpower_reg <= 1'b0;
            if (opSense) result_reg <= senseStatus;
            if (opDrive) result_reg <= driveStatus;
            if (opWake) result_reg <= 8'h00;
            if (opReadId) begin
                readid_reg <= 1'b1;
                index_reg <= 2'h0;
            end else if (readid_reg && id_field_valid) begin
                readid_reg <= 1'b0;
                id_reg <= id_field_data;
                result_reg <= {fdc_pos_pkg::TC_NORMAL, 6'h00};
            end else if (readid_reg && indexRise) begin
                if (index_reg + 2'h1 == fdc_pos_pkg::INDEX_LIMIT) begin
                    readid_reg <= 1'b0;
                    result_reg <= {fdc_pos_pkg::TC_ABNORMAL, 6'h01}; // bit0 absent id
                end
                index_reg <= index_reg + 2'h1;
            end
        end
    end

    // Interrupt: set by completions, cleared by sense; set wins over clear
    wire logic readIdEnd = readid_reg && (id_field_valid ||
                           (indexRise && index_reg + 2'h1 == fdc_pos_pkg::INDEX_LIMIT));
    wire logic pioReq = pioMode && byte_request;
    wire logic irqSet = (|moveDone) || readIdEnd || result_phase_event || pioReq ||
                        (pollPend_reg && pollOn && head_settled && !opSense);
    always_ff @(posedge clock) begin
        if (rst) begin
            irq_reg <= 1'b0;
            pollPend_reg <= 1'b1;
            xfer_reg <= 1'b0;
            stepOut_reg <= 4'h0;
            headOut_reg <= 4'h0;
        end else begin
            if (irqSet) irq_reg <= 1'b1;
            else if (opSense) irq_reg <= 1'b0;
            if (opSense && !anyPend) pollPend_reg <= 1'b0; // single poll interrupt
            xfer_reg <= pioReq;
            stepOut_reg <= stepPulse;
            headOut_reg <= stepHead;
        end
    end
    assign controller_irq_out = irq_reg;
    assign transfer_request_flag = xfer_reg;
    assign step_pulse_out = stepOut_reg;
    assign step_heading_out = headOut_reg;
endmodule : floppy_head_positioning_control

// ### floppy_head_positioning_control_tb.sv
// Self-checking bench for the head positioning control block
`timescale 1ns/1ns
module floppy_head_positioning_control_tb;
    logic clock = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, avs_waitrequest;
    logic index_pulse_input, id_field_valid = 1'b0, byte_request = 1'b0, head_settled = 1'b1;
    logic result_phase_event = 1'b0, controller_irq_out, transfer_request_flag;
    logic [5:0] avs_address = 6'h00;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, id_field_data = 32'h0, rd;
    logic [3:0] track_zero_input, step_pulse_out, step_heading_out;
    int miscompares = 0, num_checks = 0;
    floppy_head_positioning_control #(.STEP_UNIT(2)) i_floppy_head_positioning_control (
        .clock, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
        .avs_waitrequest, .track_zero_input, .index_pulse_input, .id_field_valid,
        .id_field_data, .byte_request, .result_phase_event, .head_settled, .step_pulse_out,
        .step_heading_out, .controller_irq_out, .transfer_request_flag);
    fdd_model i_fdd_model (.clock, .stepPulse(step_pulse_out), .stepHeading(step_heading_out),
        .trackZero(track_zero_input), .indexPulse(index_pulse_input));
    initial forever #20 clock = ~clock;
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : print_verdict
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch at %0t: %s got %h want %h", $time, m, got, exp);
        end
    endtask : chk
    // Avalon access held until waitrequest is seen low; an idle edge follows
    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d);
        int n;
        n = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        do begin
            @(posedge clock);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clock);
        if (n >= 50) chk(32'h0, 32'h1, "bus hang");
        if (n >= 50) print_verdict();
    endtask : bus
    task automatic cmd(input logic [3:0] op, input logic [1:0] dr, input logic [7:0] t);
        bus(1'b1, fdc_pos_pkg::CMD_OFS, {16'h0, t, 2'b00, dr, op});
    endtask : cmd
    // Moves take thousands of cycles, so the wait is long but bounded
    task automatic wait_irq;
        int n;
        n = 0;
        while (controller_irq_out !== 1'b1 && n < 20000) begin
            @(posedge clock);
            n++;
        end
        if (n >= 20000) chk(32'h0, 32'h1, "interrupt hang");
        if (n >= 20000) print_verdict();
    endtask : wait_irq
    task automatic sense(input logic [31:0] exp, input string m);
        wait_irq();
        cmd(fdc_pos_pkg::OP_SENSE_INT, 2'h0, 8'h00);
        bus(1'b0, fdc_pos_pkg::RES_OFS, 32'h0);
        chk(rd & 32'hFF, exp, m);
        $display("test %s done", m);
    endtask : sense
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        sense(32'hC0, "poll");
        chk({31'h0, controller_irq_out}, 32'h0, "irq after sense");
        bus(1'b0, fdc_pos_pkg::STEP_OFS, 32'h0);
        chk(rd & 32'hF, 32'h8, "step reset value");
        bus(1'b1, fdc_pos_pkg::STEP_OFS, 32'hF);
        cmd(fdc_pos_pkg::OP_RECAL, 2'h0, 8'h00);
        bus(1'b0, fdc_pos_pkg::STAT_OFS, 32'h0);
        chk(rd & 32'h7C0, 32'h040, "not busy while moving");
        sense(32'h20, "recal");
        chk(i_fdd_model.pos[0], 32'h0, "head home");
        cmd(fdc_pos_pkg::OP_SEEK, 2'h0, 8'h0C);
        cmd(fdc_pos_pkg::OP_SEEK, 2'h1, 8'h03);
        sense(32'h21, "seek drive one");
        sense(32'h20, "seek in");
        chk(i_fdd_model.pos[0], 32'hC, "inward track");
        cmd(fdc_pos_pkg::OP_SEEK, 2'h0, 8'h04);
        sense(32'h20, "seek out");
        chk(i_fdd_model.pos[0], 32'h4, "outward track");
        cmd(fdc_pos_pkg::OP_RECAL, 2'h3, 8'h00);
        sense(32'h73, "recal fault");
        chk(i_fdd_model.pos[3], 32'h15, "step limit");
        cmd(fdc_pos_pkg::OP_LOW_POWER, 2'h0, 8'h00);
        cmd(fdc_pos_pkg::OP_WAKE, 2'h0, 8'h00);
        cmd(fdc_pos_pkg::OP_SEEK, 2'h0, 8'h02);
        sense(32'h20, "wake clears count");
        chk(i_fdd_model.pos[0], 32'h6, "track count cleared");
        cmd(fdc_pos_pkg::OP_SENSE_DRV, 2'h0, 8'h00);
        bus(1'b0, fdc_pos_pkg::RES_OFS, 32'h0);
        chk(rd, 32'h20, "drive status");
        chk({31'h0, controller_irq_out}, 32'h0, "sense drive quiet");
        cmd(fdc_pos_pkg::OP_READ_ID, 2'h0, 8'h00);
        id_field_data <= 32'h2A010502;
        id_field_valid <= 1'b1;
        @(posedge clock);
        id_field_valid <= 1'b0;
        wait_irq();
        bus(1'b0, fdc_pos_pkg::ID_OFS, 32'h0);
        chk(rd, 32'h2A010502, "id captured");
        cmd(fdc_pos_pkg::OP_SENSE_INT, 2'h0, 8'h00);
        cmd(fdc_pos_pkg::OP_READ_ID, 2'h0, 8'h00);
        wait_irq();
        bus(1'b0, fdc_pos_pkg::RES_OFS, 32'h0);
        chk(rd, 32'h41, "no id");
        bus(1'b0, fdc_pos_pkg::FMT_OFS, 32'h0);
        chk(rd, 32'hFF281A0B, "gap layout");
        bus(1'b0, 6'h3C, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        print_verdict();
    end
endmodule : floppy_head_positioning_control_tb
bind floppy_head_positioning_control fhpc_properties i_fhpc_properties (.clock, .rst,
    .avs_read, .avs_write, .avs_waitrequest, .controller_irq_out, .avs_address,
    .avs_writedata, .avs_readdata, .track_zero_input, .step_pulse_out, .step_heading_out);

// ### step_if.sv
// Interface joining the top block to one drive step sequencer
`timescale 1ns/1ns
interface step_if;
    logic startRecal;
    logic startSeek;
    logic [7:0] targetTrack;
    logic [3:0] stepIntervalSetting;
    logic clearTrack;
    logic trackZeroInput;
    logic stepPulse;
    logic stepHeading;
    logic moveDone;
    logic moveFault;
    logic [7:0] presentTrackCount;
    logic moving;
    modport ctl (output startRecal, startSeek, targetTrack, stepIntervalSetting, clearTrack,
                 trackZeroInput, input stepPulse, stepHeading, moveDone, moveFault,
                 presentTrackCount, moving);
    modport seq (input startRecal, startSeek, targetTrack, stepIntervalSetting, clearTrack,
                 trackZeroInput, output stepPulse, stepHeading, moveDone, moveFault,
                 presentTrackCount, moving);
endinterface : step_if

// ### step_sequencer.sv
// Seek and recalibrate step sequencer for one drive
`timescale 1ns/1ns
module step_sequencer #(
    parameter int STEP_UNIT = fdc_pos_pkg::STEP_UNIT_CYC
) (
    input wire logic clock,
    input wire logic rst,
    step_if.seq sif
);
    fdc_pos_pkg::move_state_t state_reg, state_next;
    logic recal_reg;
    logic [7:0] track_reg;
    logic [7:0] steps_reg;
    logic [19:0] timer_reg;
    logic dir_reg;
    logic fault_reg;
    logic first_reg;
    logic [7:0] goal_reg;
    // ****************************************************
    // Step decisions
    // ****************************************************
    wire logic timerDone = (timer_reg == 20'h00000);
    wire logic seekAtTarget = (track_reg == goal_reg);
    wire logic recalAtZero = sif.trackZeroInput;
    wire logic recalOut = (steps_reg >= fdc_pos_pkg::RECAL_MAX_STEPS);
    wire logic finished = recal_reg ? (recalAtZero || recalOut) : seekAtTarget;
    // First interval is half length; allowed to be shorter than the rest
    wire logic [19:0] gapCycles = 20'(({1'b0, 4'hF - sif.stepIntervalSetting} + 5'h01)
                                  * STEP_UNIT) >> first_reg;
    wire logic [7:0] trackStep = dir_reg ? track_reg + 8'h01 : track_reg - 8'h01;
    // Next-state logic of the movement
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            fdc_pos_pkg::MV_IDLE:
                if (sif.startRecal || sif.startSeek) state_next = fdc_pos_pkg::MV_WAIT;
            fdc_pos_pkg::MV_WAIT:
                if (finished) state_next = fdc_pos_pkg::MV_DONE;
                else if (timerDone) state_next = fdc_pos_pkg::MV_PULSE;
            fdc_pos_pkg::MV_PULSE:
                if (timerDone) state_next = fdc_pos_pkg::MV_WAIT;
            fdc_pos_pkg::MV_DONE:
                state_next = fdc_pos_pkg::MV_IDLE;
            default:
                state_next = fdc_pos_pkg::MV_IDLE;
        endcase
    end
    // State and counters
    always_ff @(posedge clock) begin
        if (rst) begin
            state_reg <= fdc_pos_pkg::MV_IDLE;
            recal_reg <= 1'b0;
            track_reg <= 8'h00;
            steps_reg <= 8'h00;
            timer_reg <= 20'h00000;
            dir_reg <= 1'b0;
            fault_reg <= 1'b0;
            first_reg <= 1'b0;
            goal_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (sif.clearTrack) begin
                track_reg <= 8'h00;
            end
            case (state_reg)
                fdc_pos_pkg::MV_IDLE: if (sif.startRecal) begin
                    recal_reg <= 1'b1;
                    track_reg <= 8'h00;
                    dir_reg <= 1'b0;
                    steps_reg <= 8'h00;
                    timer_reg <= 20'h00000;
                    first_reg <= 1'b1;
                    fault_reg <= 1'b0;
                end else if (sif.startSeek) begin
                    recal_reg <= 1'b0;
                    dir_reg <= (track_reg < sif.targetTrack);
                    goal_reg <= sif.targetTrack;
                    timer_reg <= 20'h00000;
                    first_reg <= 1'b1;
                    fault_reg <= 1'b0;
                end
                fdc_pos_pkg::MV_WAIT: if (finished) begin
                    fault_reg <= recal_reg && !recalAtZero;
                end else if (timerDone) begin
                    timer_reg <= 20'(fdc_pos_pkg::STEP_PULSE_CYC);
                end else begin
                    timer_reg <= timer_reg - 20'h00001;
                end
                fdc_pos_pkg::MV_PULSE: if (timerDone) begin
                    timer_reg <= gapCycles;
                    first_reg <= 1'b0;
                    steps_reg <= steps_reg + 8'h01;
                    if (!recal_reg) track_reg <= trackStep;
                end else begin
                    timer_reg <= timer_reg - 20'h00001;
                end
                default: begin
                end
            endcase
        end
    end
    assign sif.stepPulse = (state_reg == fdc_pos_pkg::MV_PULSE);
    assign sif.stepHeading = dir_reg;
    assign sif.moveDone = (state_reg == fdc_pos_pkg::MV_DONE);
    assign sif.moveFault = fault_reg;
    assign sif.presentTrackCount = track_reg;
    assign sif.moving = (state_reg != fdc_pos_pkg::MV_IDLE);
endmodule : step_sequencer
